// [prhg_core.v]
// Raw-bit health gate with a small output FIFO, packing 32-bit random words.
// Assumes an asynchronous entropy bit with its own strobe, both from outside the clock.
`timescale 1ns/1ps
`include "prhg_defines.vh"

// Small FIFO of parameterised width and depth
module prhg_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 4,
  parameter AW = 2
)(
  // Clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // Fill side
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  // Drain side
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;
  assign o_in_ready = (cnt_reg != DEPTH[AW:0]);
  assign o_out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign o_out_data = mem_reg[rd_reg];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  // Pointers; flush empties so no stale word survives a failure
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else if (i_flush)
    begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
      if (push & ~pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (pop & ~push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
  // Storage has no reset; contents are masked by the count
  always @(posedge i_mclk)
  begin
    if (push)
      mem_reg[wr_reg] <= i_in_data;
  end
endmodule // prhg_fifo

module prhg_core #(
  parameter WORD_BITS = `PRHG_WORD_BITS,
  parameter FIFO_DEPTH = 4
)(
  // Clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // Raw entropy source, asynchronous
  input wire i_raw_bit,
  input wire i_raw_strobe,
  // Random word output
  output reg o_word_valid,
  input wire i_word_ready,
  output reg [WORD_BITS-1:0] o_word,
  // Health status
  output reg o_fail,
  output reg o_ready
);
  reg [1:0] bit_sync_reg;
  reg [2:0] stb_sync_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg last_bit_reg;
  reg [6:0] run_reg;
  reg [11:0] win_reg;
  reg [11:0] ones_reg;
  reg [3:0] wins_reg;
  reg [WORD_BITS-1:0] sh_reg;
  reg [5:0] nbit_reg;
  reg pack_valid_reg;
  wire raw_bit;
  wire raw_take;
  wire stuck;
  wire win_end;
  wire win_bad;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WORD_BITS-1:0] fifo_out_data;
  wire defect;
  wire take_out;
  wire word_ripe;
  reg [2:0] held_reg;
  // Words that a stuck run starting in them can still reach before it is seen
  localparam integer HOLD_WORDS = (`PRHG_RUN_LIMIT + WORD_BITS - 2) / WORD_BITS;

  // Two-stage synchronisers; the strobe gets a third stage for edge detect
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bit_sync_reg <= 2'h0;
      stb_sync_reg <= 3'h0;
    end
    else
    begin
      bit_sync_reg <= {bit_sync_reg[0], i_raw_bit};
      stb_sync_reg <= {stb_sync_reg[1:0], i_raw_strobe};
    end
  end
  assign raw_bit = bit_sync_reg[1];
  assign raw_take = stb_sync_reg[1] & ~stb_sync_reg[2];

  assign stuck = raw_take && (raw_bit == last_bit_reg) && (run_reg == `PRHG_RUN_LIMIT - 7'h01);
  assign win_end = raw_take && (win_reg == `PRHG_WIN_BITS - 12'h001);
  assign win_bad = win_end && (((ones_reg + {11'h000, raw_bit}) < `PRHG_ONES_LO) ||
    ((ones_reg + {11'h000, raw_bit}) > `PRHG_ONES_HI));
  assign defect = stuck | win_bad;

  // Health counters run on every raw bit, continuously
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      last_bit_reg <= 1'b0;
      run_reg <= 7'h00;
      win_reg <= 12'h000;
      ones_reg <= 12'h000;
      wins_reg <= 4'h0;
    end
    else if (raw_take)
    begin
      last_bit_reg <= raw_bit;
      run_reg <= (raw_bit == last_bit_reg) ? run_reg + 7'h01 : 7'h01;
      if (win_end)
      begin
        win_reg <= 12'h000;
        ones_reg <= 12'h000;
        if (!win_bad && wins_reg != `PRHG_STARTUP_WINS)
          wins_reg <= wins_reg + 4'h1;
      end
      else
      begin
        win_reg <= win_reg + 12'h001;
        ones_reg <= ones_reg + {11'h000, raw_bit};
      end
    end
  end

  // gate state machine; fail is terminal until reset
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `PRHG_ST_STARTUP:
        if (defect)
          state_next = `PRHG_ST_FAIL;
        else if (wins_reg == `PRHG_STARTUP_WINS)
          state_next = `PRHG_ST_RUN;
      `PRHG_ST_RUN:
        if (defect)
          state_next = `PRHG_ST_FAIL;
      default:
        state_next = `PRHG_ST_FAIL;
    endcase
  end
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      state_reg <= `PRHG_ST_STARTUP;
    else
      state_reg <= state_next;
  end

  // pack raw bits into words; partial word dropped on failure
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sh_reg <= {WORD_BITS{1'b0}};
      nbit_reg <= 6'h00;
      pack_valid_reg <= 1'b0;
    end
    else
    begin
      if (pack_valid_reg && fifo_in_ready)
        pack_valid_reg <= 1'b0;
      if (state_reg != `PRHG_ST_RUN || defect)
      begin
        nbit_reg <= 6'h00;
        pack_valid_reg <= 1'b0;
      end
      // Source bits are lost while the packed word waits; that only costs rate
      else if (raw_take && !pack_valid_reg)
      begin
        sh_reg <= {sh_reg[WORD_BITS-2:0], raw_bit};
        if (nbit_reg == WORD_BITS[5:0] - 6'h01)
        begin
          nbit_reg <= 6'h00;
          pack_valid_reg <= 1'b1;
        end
        else
          nbit_reg <= nbit_reg + 6'h01;
      end
    end
  end

  // hold words until enough later bits passed the stuck test
  // Costs latency only; a failure found meanwhile flushes the held words
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
      held_reg <= 3'h0;
    else if (state_reg == `PRHG_ST_FAIL || defect)
      held_reg <= 3'h0;
    else
      held_reg <= held_reg + {2'h0, pack_valid_reg & fifo_in_ready} - {2'h0, fifo_out_valid & take_out & word_ripe};
  end
  assign word_ripe = (held_reg > HOLD_WORDS[2:0]);

  prhg_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_flush(state_reg == `PRHG_ST_FAIL || defect),
    .i_in_valid(pack_valid_reg),
    .o_in_ready(fifo_in_ready),
    .i_in_data(sh_reg),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(take_out & word_ripe),
    .o_out_data(fifo_out_data)
  );

  // Registered output stage; load when empty or consumed
  assign take_out = (!o_word_valid || i_word_ready) && state_reg == `PRHG_ST_RUN && !defect;
  // valid drops at once on any defect
  always @(posedge i_mclk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_word_valid <= 1'b0;
      o_word <= {WORD_BITS{1'b0}};
      o_fail <= 1'b0;
      o_ready <= 1'b0;
    end
    else
    begin
      if (defect || state_reg == `PRHG_ST_FAIL)
        o_word_valid <= 1'b0;
      else if (take_out)
      begin
        o_word_valid <= fifo_out_valid & word_ripe;
        // Unreleased words never reach the pins
        if (word_ripe)
          o_word <= fifo_out_data;
      end
      o_fail <= o_fail | defect;
      o_ready <= (state_next == `PRHG_ST_RUN);
    end
  end
endmodule // prhg_core

// [prhg_defines.vh]
// Constants for the physical random generator health gate.
// Assumes a 40 MHz system clock; included by the design file only.
`ifndef PRHG_DEFINES_VH
`define PRHG_DEFINES_VH
`define PRHG_CLK_MHZ 40
`define PRHG_WORD_BITS 32
// Stuck-source limit: equal raw bits in a row that mean total failure
`define PRHG_RUN_LIMIT 7'h0040
// Window length in raw bits for the ones-count test
`define PRHG_WIN_BITS 12'h0400
// Accepted ones count band within one window
`define PRHG_ONES_LO 12'h01b0
`define PRHG_ONES_HI 12'h0250
// Power-up windows that must pass before output opens
`define PRHG_STARTUP_WINS 4'h2
// Gate states
`define PRHG_ST_STARTUP 2'h0
`define PRHG_ST_RUN 2'h1
`define PRHG_ST_FAIL 2'h2
`endif

// [prhg_consumer.sv]
// Consumer model: takes random words from the core, stalling one cycle in three.
// Assumes the core's valid/ready handshake on the rising clock edge.
`timescale 1ns/1ps
module prhg_consumer (
  // Clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // Word handshake
  input wire i_valid,
  output wire o_ready,
  output wire o_take
);
  reg [1:0] ph_reg;
  // Stall pattern, so a waiting word must be held
  always @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst) ph_reg <= 2'h0;
    else ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
  assign o_ready = ph_reg != 2'h0;
  assign o_take = i_valid && o_ready;
endmodule // prhg_consumer

// [prhg_core_props.sv]
// Checker for the health gate core: output gating and failure behaviour.
// Assumes it is bound to the core and sees only the core's ports.
`timescale 1ns/1ps
module prhg_core_props #(parameter WORD_BITS = 32, parameter FIFO_DEPTH = 4) (
  // Core ports
  input wire i_mclk,
  input wire i_nrst,
  input wire i_raw_bit,
  input wire i_raw_strobe,
  input wire o_word_valid,
  input wire i_word_ready,
  input wire [WORD_BITS-1:0] o_word,
  input wire o_fail,
  input wire o_ready
);
  reg stb_reg, last_reg;
  reg [11:0] cnt_reg;
  reg [6:0] run_reg;
  // Strobe edges for start-up, equal-bit runs saturating at the stuck limit
  always @(posedge i_mclk or negedge i_nrst)
    if (!i_nrst)
      {stb_reg, last_reg, cnt_reg, run_reg} <= 21'h0;
    else
    begin
      stb_reg <= i_raw_strobe;
      if (i_raw_strobe && !stb_reg)
      begin
        cnt_reg <= cnt_reg + {11'h0, !cnt_reg[11]};
        last_reg <= i_raw_bit;
        run_reg <= (i_raw_bit == last_reg && run_reg != 7'h0) ? run_reg + {6'h0, run_reg != 7'h40} : 7'h1;
      end
    end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  a_fail_no_valid: assert property (o_fail |-> !o_word_valid) else $error("valid while failed");
  a_fail_sticky: assert property (o_fail |=> o_fail) else $error("fail cleared");
  a_fail_not_ready: assert property (o_fail |-> !o_ready) else $error("ready while failed");
  a_valid_needs_ready: assert property (o_word_valid |-> o_ready) else $error("word before ready");
  a_word_held: assert property (o_word_valid && !i_word_ready |=> (o_word_valid && $stable(o_word)) || o_fail)
    else $error("word not held");
  a_ready_stays: assert property (o_ready |=> o_ready || o_fail) else $error("ready dropped");
  a_startup_closed: assert property (cnt_reg < 12'h800 |-> !o_ready && !o_word_valid) else $error("early open");
  a_stuck_fail: assert property (run_reg == 7'h40 |-> ##[1:10] o_fail) else $error("stuck not seen");
endmodule // prhg_core_props
bind prhg_core prhg_core_props #(.WORD_BITS(WORD_BITS), .FIFO_DEPTH(FIFO_DEPTH)) chk (.i_mclk(i_mclk),
  .i_nrst(i_nrst), .i_raw_bit(i_raw_bit), .i_raw_strobe(i_raw_strobe), .o_word_valid(o_word_valid),
  .i_word_ready(i_word_ready), .o_word(o_word), .o_fail(o_fail), .o_ready(o_ready));

// [tb_physical_rng_health_gate.sv]
// Testbench for the health gate: start-up, word order, stuck and biased source.
// Assumes the core, its bound checker and the consumer model are compiled first.
`timescale 1ns/1ps
module tb_physical_rng_health_gate;
  logic i_mclk = 0, i_nrst = 0, i_raw_bit = 0, i_raw_strobe = 0;
  logic o_word_valid, o_fail, o_ready, rdy, take, synced = 0;
  logic [31:0] o_word, lfsr = 32'h5e9a, shreg = 0;
  logic [31:0] notes[$];
  int errors = 0, comparisons = 0, nb = 0;
  // Free-running 40 MHz clock
  always #12.5 i_mclk = ~i_mclk;
  prhg_core uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_raw_bit(i_raw_bit), .i_raw_strobe(i_raw_strobe),
    .o_word_valid(o_word_valid), .i_word_ready(rdy), .o_word(o_word), .o_fail(o_fail), .o_ready(o_ready));
  prhg_consumer cons (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_valid(o_word_valid), .o_ready(rdy), .o_take(take));
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One raw bit; data settles a cycle before the strobe, note made before the word can appear
  task automatic send(input logic b);
    i_raw_bit <= b;
    @(posedge i_mclk) i_raw_strobe <= 1;
    shreg = {shreg[30:0], b};
    nb++;
    if (nb % 32 == 0) notes.push_back(shreg);
    repeat (4) @(posedge i_mclk);
    i_raw_strobe <= 0;
    repeat (4) @(posedge i_mclk);
  endtask
  // Mode 0 random, 1 stuck at one, 2 biased 1110 pattern
  task automatic bits(input int n, input int mode);
    repeat (n) begin
      lfsr = step(lfsr);
      send(mode == 0 ? lfsr[0] : mode == 1 ? 1'b1 : nb % 4 != 3);
    end
  endtask
  task automatic do_reset;
    i_nrst <= 0;
    repeat (12) @(posedge i_mclk);
    i_nrst <= 1;
    notes.delete();
    nb = 0;
    synced = 0;
  endtask
  // Taken word against oldest note; start-up groups may be skipped once
  always @(posedge i_mclk)
  begin
    if (take)
    begin
      while (!synced && notes.size() > 1 && notes[0] !== o_word)
        void'(notes.pop_front());
      synced = 1;
      if (notes.size() == 0)
        check(o_word, 32'hxxxx_xxxx);
      else
        check(o_word, notes.pop_front());
      // A word built from stuck-source bits must never be taken
      check(32'(o_word == 32'hffff_ffff), 32'h0);
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    do_reset;
    bits(1024, 0);
    check(32'(o_ready), 32'h0);
    bits(1088, 0);
    check(32'(o_ready), 32'h1);
    bits(320, 0);
    check(32'(synced), 32'h1);
    $display("test startup and words done");
    bits(70, 1);
    check(32'({o_fail, o_ready, o_word_valid}), 32'h4);
    bits(64, 0);
    check(32'({o_fail, o_word_valid}), 32'h2);
    $display("test stuck source done");
    do_reset;
    bits(1100, 2);
    check(32'({o_fail, o_ready}), 32'h2);
    $display("test biased source done");
    print_verdict;
  end
  // Watchdog well past the roughly 33k cycles the tests need
  initial begin
    #1_500_000;
    errors++;
    print_verdict;
  end
endmodule // tb_physical_rng_health_gate
